// >>> scb_pkg.sv
// constants for the synthesizer control register bank
// Function
// - oscillator performance field: 3 selects high performance, 1 selects low current
// - write to integer or fractional register starts frequency change, autocal when enabled
// - autocal disable bit set skips automatic calibration, uses manual settings
// - return loss bit: 0 maximum power, 1 improved return loss
// - four-bit gain field sets output gain 0 to 11 dB
// - mute field: 3 mute on, 1 mute off
// - output enable field gates positive and negative outputs
// - offset 0 reads fixed 24-bit identity, writes never change it
// - write to offset 0 stores bits 4:0 as next readback address
// - bit 5 of offset 0 write is soft reset strobe, host keeps 0
// - enable register bit 0 selects pin or serial bit as power-down source
// - enable register bit 1 is serial enable, resets to 0x000002
// - cycle after read-address write shifts selected register out on serial line
// - 32-bit frame MSB first: data, register address, chip address, commit on strobe
package scb_pkg;
    localparam int DATA_W = 24;
    localparam int ADDR_W = 5;
    localparam int CHIP_W = 3;
    localparam int FRAME_W = DATA_W + ADDR_W + CHIP_W;
    localparam logic [ADDR_W-1:0] OFS_ID = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_ENABLE = 5'h01;
    localparam logic [ADDR_W-1:0] OFS_INTEGER = 5'h03;
    localparam logic [ADDR_W-1:0] OFS_FRACTION = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_OSC = 5'h05;
    localparam logic [ADDR_W-1:0] OFS_CAL = 5'h0A;
    localparam logic [CHIP_W-1:0] CHIP_ADDR = 3'h0;
    // arbitrary identity value
    localparam logic [DATA_W-1:0] PART_IDENTITY = 24'hA5C3E1;
    localparam logic [DATA_W-1:0] RST_ENABLE = 24'h000002;
    localparam logic [DATA_W-1:0] RST_INTEGER = 24'h000019;
    localparam logic [DATA_W-1:0] RST_FRACTION = 24'h000000;
    localparam logic [DATA_W-1:0] RST_OSC = 24'h000000;
    localparam logic [DATA_W-1:0] RST_CAL = 24'h000000;
    localparam logic [9:0] ENABLE_MASK = 10'h3FF;
    localparam int BIT_PIN_SEL = 0;
    localparam int BIT_SER_EN = 1;
    localparam int BIT_SOFT_RST = 5;
    localparam int BIT_CAL_DIS = 11;
    // oscillator-side register written through offset 5: id[2:0], subaddr[6:3], data[15:7]
    localparam int OSC_ID_LSB = 0;
    localparam int OSC_SUB_LSB = 3;
    localparam int OSC_SUB_W = 4;
    localparam int OSC_DAT_LSB = 7;
    localparam int OSC_DAT_W = 9;
    localparam logic [OSC_SUB_W-1:0] OSC_SUB_CFG = 4'h3;
    localparam logic [OSC_SUB_W-1:0] OSC_SUB_GAIN = 4'h7;
    localparam int CFG_PERF_LSB = 0;
    localparam int CFG_OE_LSB = 2;
    localparam int CFG_RL_BIT = 5;
    localparam int CFG_MUTE_LSB = 7;
    localparam logic [1:0] PERF_HIGH = 2'h3;
    localparam logic [1:0] PERF_LOW = 2'h1;
    localparam logic [1:0] MUTE_ON = 2'h3;
    localparam logic [1:0] MUTE_OFF = 2'h1;
    localparam logic [OSC_DAT_W-1:0] RST_OSC_CFG = 9'h000;
    localparam logic [3:0] RST_GAIN = 4'h0;
    localparam logic [3:0] GAIN_MAX = 4'hB;
endpackage

// >>> scb_top.sv
// synthesizer control register bank behind the four-wire serial port
`timescale 1ns/1ns
module scb_top (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic ser_clk,
    input wire logic ser_data_in,
    input wire logic ser_enable,
    input wire logic external_enable_pin,
    input wire logic lock_detect,
    output logic lock_or_serial_out,
    output logic lock_or_serial_out_oe,
    output logic synth_powered,
    output logic freq_change,
    output logic autocal_start,
    output logic high_performance,
    output logic low_current,
    output logic return_loss_select,
    output logic [3:0] output_gain,
    output logic mute_active,
    output logic [1:0] output_enable
);
    import scb_pkg::*;

    // ==================================================
    // link domain: shift register on the serial clock
    logic [FRAME_W-1:0] shift_in;
    logic [DATA_W-1:0] shift_out;
    logic [5:0] bit_count;
    logic frame_start;
    logic [DATA_W-1:0] read_word;

    always_ff @(posedge ser_clk) begin
        shift_in <= {shift_in[FRAME_W-2:0], ser_data_in};
    end

    // serial clock is still while the strobe is high, so the strobe clears the count
    always_ff @(posedge ser_clk or posedge ser_enable) begin
        if (ser_enable) begin
            bit_count <= '0;
        end else if (bit_count != 6'(FRAME_W)) begin
            bit_count <= bit_count + 6'h01;
        end
    end
    assign frame_start = bit_count == '0;

    always_ff @(posedge ser_clk) begin
        if (frame_start) begin
            shift_out <= {read_word[DATA_W-2:0], 1'b0};
        end else begin
            shift_out <= {shift_out[DATA_W-2:0], 1'b0};
        end
    end

    // ==================================================
    // frame capture: strobe rising edge commits frame held in link domain
    logic [2:0] sen_sync;
    logic [FRAME_W-1:0] frame_hold;
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sen_sync <= 3'h0;
        end else begin
            sen_sync <= {sen_sync[1:0], ser_enable};
        end
    end
    wire sen_rise = sen_sync[1] && !sen_sync[2];

    // ser_clk is idle while the strobe is high, so the frame is stable here
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            frame_hold <= '0;
        end else if (sen_sync[1]) begin
            frame_hold <= shift_in;
        end
    end

    logic commit;
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            commit <= 1'b0;
        end else begin
            commit <= sen_rise;
        end
    end

    wire [DATA_W-1:0] wr_data = frame_hold[FRAME_W-1 -: DATA_W];
    wire [ADDR_W-1:0] wr_addr = frame_hold[CHIP_W +: ADDR_W];
    wire [CHIP_W-1:0] wr_chip = frame_hold[CHIP_W-1:0];
    wire wr_ok = commit && wr_chip == CHIP_ADDR;

    function automatic logic is_write(input logic ok, input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] t);
        return ok && a == t;
    endfunction

    // ==================================================
    // registers
    wire soft_reset = is_write(wr_ok, wr_addr, OFS_ID) && wr_data[BIT_SOFT_RST];
    logic [ADDR_W-1:0] read_addr;
    logic [9:0] enable_ctrl;
    logic [DATA_W-1:0] integer_reg;
    logic [DATA_W-1:0] fraction_reg;
    logic [DATA_W-1:0] osc_reg;
    logic [DATA_W-1:0] cal_reg;
    logic [OSC_DAT_W-1:0] osc_cfg;
    logic [3:0] osc_gain;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            read_addr <= '0;
        end else if (is_write(wr_ok, wr_addr, OFS_ID)) begin
            read_addr <= wr_data[ADDR_W-1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst || soft_reset) begin
            enable_ctrl <= RST_ENABLE[9:0];
        end else if (is_write(wr_ok, wr_addr, OFS_ENABLE)) begin
            enable_ctrl <= wr_data[9:0] & ENABLE_MASK;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst || soft_reset) begin
            integer_reg <= RST_INTEGER;
        end else if (is_write(wr_ok, wr_addr, OFS_INTEGER)) begin
            integer_reg <= wr_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst || soft_reset) begin
            fraction_reg <= RST_FRACTION;
        end else if (is_write(wr_ok, wr_addr, OFS_FRACTION)) begin
            fraction_reg <= wr_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst || soft_reset) begin
            osc_reg <= RST_OSC;
        end else if (is_write(wr_ok, wr_addr, OFS_OSC)) begin
            osc_reg <= wr_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst || soft_reset) begin
            cal_reg <= RST_CAL;
        end else if (is_write(wr_ok, wr_addr, OFS_CAL)) begin
            cal_reg <= wr_data;
        end
    end

    // oscillator-side registers reached through the forwarding register
    wire osc_wr = is_write(wr_ok, wr_addr, OFS_OSC);
    wire [OSC_SUB_W-1:0] osc_sub = wr_data[OSC_SUB_LSB +: OSC_SUB_W];
    wire [OSC_DAT_W-1:0] osc_dat = wr_data[OSC_DAT_LSB +: OSC_DAT_W];
    always_ff @(posedge ref_clk) begin
        if (!nrst || soft_reset) begin
            osc_cfg <= RST_OSC_CFG;
        end else if (osc_wr && osc_sub == OSC_SUB_CFG) begin
            osc_cfg <= osc_dat;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst || soft_reset) begin
            osc_gain <= RST_GAIN;
        end else if (osc_wr && osc_sub == OSC_SUB_GAIN) begin
            osc_gain <= (osc_dat[3:0] > GAIN_MAX) ? GAIN_MAX : osc_dat[3:0];
        end
    end

    // ==================================================
    // outputs
    wire freq_wr = is_write(wr_ok, wr_addr, OFS_INTEGER) || is_write(wr_ok, wr_addr, OFS_FRACTION);
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            freq_change <= 1'b0;
        end else begin
            freq_change <= freq_wr;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            autocal_start <= 1'b0;
        end else begin
            autocal_start <= freq_wr && !cal_reg[BIT_CAL_DIS];
        end
    end

    // two-stage synchroniser for the power-down pin
    logic [1:0] pin_sync;
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pin_sync <= 2'h0;
        end else begin
            pin_sync <= {pin_sync[0], external_enable_pin};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            synth_powered <= 1'b0;
        end else if (enable_ctrl[BIT_PIN_SEL]) begin
            synth_powered <= pin_sync[1];
        end else begin
            synth_powered <= enable_ctrl[BIT_SER_EN];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            high_performance <= 1'b0;
        end else begin
            high_performance <= osc_cfg[CFG_PERF_LSB +: 2] == PERF_HIGH;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            low_current <= 1'b0;
        end else begin
            low_current <= osc_cfg[CFG_PERF_LSB +: 2] == PERF_LOW;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            return_loss_select <= 1'b0;
        end else begin
            return_loss_select <= osc_cfg[CFG_RL_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            output_gain <= RST_GAIN;
        end else begin
            output_gain <= osc_gain;
        end
    end

    // mute field values other than on and off leave the mute state as it is
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            mute_active <= 1'b0;
        end else if (osc_cfg[CFG_MUTE_LSB +: 2] == MUTE_ON) begin
            mute_active <= 1'b1;
        end else if (osc_cfg[CFG_MUTE_LSB +: 2] == MUTE_OFF) begin
            mute_active <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            output_enable <= 2'h0;
        end else begin
            output_enable <= osc_cfg[CFG_OE_LSB +: 2];
        end
    end

    // ==================================================
    // readback word follows the registers only while the strobe is high, so it stands still while shifted out
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            read_word <= '0;
        end else if (sen_sync[1]) begin
            unique case (read_addr)
                OFS_ID: read_word <= PART_IDENTITY;
                OFS_ENABLE: read_word <= {14'h0000, enable_ctrl};
                OFS_INTEGER: read_word <= integer_reg;
                OFS_FRACTION: read_word <= fraction_reg;
                OFS_OSC: read_word <= osc_reg;
                OFS_CAL: read_word <= cal_reg;
                default: read_word <= '0;
            endcase
        end
    end

    // serial output: first bit straight from the readback word, then the shifter
    always_ff @(posedge ser_clk) begin
        if (frame_start) begin
            lock_or_serial_out <= read_word[DATA_W-1];
        end else begin
            lock_or_serial_out <= shift_out[DATA_W-1];
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            lock_or_serial_out_oe <= 1'b0;
        end else begin
            lock_or_serial_out_oe <= 1'b1;
        end
    end
endmodule

// >>> scb_assertions.sv
// concurrent checks on the register bank ports
`timescale 1ns/1ns
module scb_checker (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic ser_enable,
    input wire logic lock_or_serial_out_oe,
    input wire logic synth_powered,
    input wire logic freq_change,
    input wire logic autocal_start,
    input wire logic high_performance,
    input wire logic low_current,
    input wire logic [3:0] output_gain,
    input wire logic mute_active,
    input wire logic [1:0] output_enable
);
    // ========================================
    // strobe history
    logic [7:0] sen_hist = 8'h00;
    always_ff @(posedge ref_clk) begin
        sen_hist <= {sen_hist[6:0], ser_enable};
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // ========================================
    // properties
    chk_cal_with_change: assert property (autocal_start |-> freq_change)
        else $error("autocal pulse without frequency change");
    chk_change_one_cycle: assert property (freq_change |=> !freq_change)
        else $error("frequency change pulse too long");
    chk_change_after_strobe: assert property ($rose(freq_change) |-> (|sen_hist))
        else $error("frequency change without a committed frame");
    chk_perf_exclusive: assert property (!(high_performance && low_current))
        else $error("both performance levels active");
    chk_gain_limit: assert property (output_gain <= 4'hB)
        else $error("gain above limit");
    chk_powered_reset: assert property ($rose(nrst) |-> ##[0:2] synth_powered)
        else $error("enable bit not set after reset");
    chk_oe_needs_strobe: assert property ($changed(output_enable) |-> (|sen_hist))
        else $error("output enable changed without a frame");
    chk_mute_needs_strobe: assert property ($changed(mute_active) |-> (|sen_hist))
        else $error("mute changed without a frame");
    chk_sdo_driven: assert property ($rose(nrst) |-> ##[0:2] lock_or_serial_out_oe)
        else $error("serial output not driven after reset");
endmodule

// >>> scb_host_model.sv
// host controller model driving the four-wire serial port
`timescale 1ns/1ns
module scb_host_model (
    input wire logic go,
    input wire logic [31:0] word,
    input wire logic lock_or_serial_out,
    output logic done,
    output logic [23:0] rdata,
    output logic ser_clk,
    output logic ser_data_in,
    output logic ser_enable
);
    initial begin
        done = 1'b0;
        rdata = 24'h000000;
        ser_clk = 1'b0;
        ser_data_in = 1'b0;
        ser_enable = 1'b0;
        forever begin
            wait (go);
            #7;
            for (int i = 31; i >= 0; i--) begin
                ser_data_in = word[i];
                #6 ser_clk = 1'b1;
                #6 ser_clk = 1'b0;
                if (i >= 8) rdata[i-8] = lock_or_serial_out;
            end
            ser_data_in = ~ser_data_in;
            #3 ser_enable = 1'b1;
            #400 ser_enable = 1'b0;
            #300 done = 1'b1;
            wait (!go);
            done = 1'b0;
        end
    end
endmodule

// >>> tb_top.sv
// testbench for the register bank
`timescale 1ns/1ns
module tb_top;
    import scb_pkg::*;
    logic ref_clk, nrst, ser_clk, ser_data_in, ser_enable, pin, go, done, sdo, sdo_oe, pwr, fc, ac;
    logic hp, lc, rl, mute;
    logic [1:0] oe;
    logic [3:0] gain;
    logic [31:0] word;
    logic [23:0] rdata, rv;
    int failures = 0;
    int n_compared = 0;
    int n_fc = 0;
    int n_ac = 0;
    scb_top dut_u (.ref_clk(ref_clk), .nrst(nrst), .ser_clk(ser_clk), .ser_data_in(ser_data_in),
        .ser_enable(ser_enable), .external_enable_pin(pin), .lock_detect(1'b0), .lock_or_serial_out(sdo),
        .lock_or_serial_out_oe(sdo_oe), .synth_powered(pwr), .freq_change(fc), .autocal_start(ac),
        .high_performance(hp), .low_current(lc), .return_loss_select(rl), .output_gain(gain),
        .mute_active(mute), .output_enable(oe));
    scb_host_model host_u (.go(go), .word(word), .lock_or_serial_out(sdo), .done(done), .rdata(rdata),
        .ser_clk(ser_clk), .ser_data_in(ser_data_in), .ser_enable(ser_enable));
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (fc === 1'b1) n_fc++;
        if (ac === 1'b1) n_ac++;
    end
    task automatic end_of_test;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic [4:0] a, input logic [23:0] d, input logic [2:0] c);
        int n;
        word <= {d, a, c};
        go <= 1'b1;
        n = 0;
        while (done !== 1'b1 && n < 200) begin
            @(posedge ref_clk);
            n++;
        end
        if (n == 200) begin
            failures++;
            end_of_test();
        end
        go <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [4:0] a);
        xfer(OFS_ID, {19'h00000, a}, CHIP_ADDR);
        xfer(OFS_ID, {19'h00000, a}, CHIP_ADDR);
        rv = rdata;
    endtask
    logic [8:0] cfg [3] = '{9'h1A7, 9'h10C, 9'h081};
    logic [5:0] cexp [3] = '{6'b101011, 6'b000111, 6'b010000};
    logic [3:0] gset [3] = '{4'h5, 4'hB, 4'hF};
    logic [3:0] gexp [3] = '{4'h5, 4'hB, 4'hB};
    initial begin
        nrst = 1'b0;
        pin = 1'b0;
        go = 1'b0;
        word = 32'h00000000;
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk({23'h0, pwr}, 24'h000001);
        chk({23'h0, sdo_oe}, 24'h000001);
        rd(OFS_ID);
        chk(rv, PART_IDENTITY);
        rd(OFS_ENABLE);
        chk(rv, RST_ENABLE);
        $display("test identity done");
        xfer(OFS_ENABLE, 24'h000000, CHIP_ADDR);
        chk({23'h0, pwr}, 24'h000000);
        pin <= 1'b1;
        xfer(OFS_ENABLE, 24'h000001, CHIP_ADDR);
        chk({23'h0, pwr}, 24'h000001);
        pin <= 1'b0;
        repeat (6) @(posedge ref_clk);
        chk({23'h0, pwr}, 24'h000000);
        xfer(OFS_ID, 24'h000020, CHIP_ADDR);
        rd(OFS_ENABLE);
        chk(rv, RST_ENABLE);
        chk({23'h0, pwr}, 24'h000001);
        $display("test enable done");
        for (int i = 0; i < 3; i++) begin
            xfer(OFS_OSC, {8'h00, cfg[i], OSC_SUB_CFG, 3'h0}, CHIP_ADDR);
            chk({18'h0, hp, lc, rl, oe, mute}, {18'h0, cexp[i]});
            xfer(OFS_OSC, {8'h00, 5'h00, gset[i], OSC_SUB_GAIN, 3'h0}, CHIP_ADDR);
            chk({20'h0, gain}, {20'h0, gexp[i]});
        end
        $display("test oscillator done");
        xfer(OFS_INTEGER, 24'h000020, CHIP_ADDR);
        xfer(OFS_FRACTION, 24'h000001, CHIP_ADDR);
        xfer(OFS_INTEGER, 24'h000030, 3'h5);
        chk(24'(n_fc), 24'h000002);
        chk(24'(n_ac), 24'h000002);
        xfer(OFS_CAL, 24'h000800, CHIP_ADDR);
        xfer(OFS_INTEGER, 24'h000021, CHIP_ADDR);
        chk(24'(n_fc), 24'h000003);
        chk(24'(n_ac), 24'h000002);
        rd(OFS_INTEGER);
        chk(rv, 24'h000021);
        rd(OFS_OSC);
        chk(rv, {8'h00, 5'h00, 4'hF, OSC_SUB_GAIN, 3'h0});
        rd(5'h02);
        chk(rv, 24'h000000);
        xfer(OFS_ID, 24'h000020, CHIP_ADDR);
        rd(OFS_INTEGER);
        chk(rv, RST_INTEGER);
        chk({20'h0, gain}, {20'h0, RST_GAIN});
        $display("test frequency done");
        end_of_test();
    end
endmodule
bind scb_top scb_checker chk_u (.ref_clk(ref_clk), .nrst(nrst), .ser_enable(ser_enable),
    .lock_or_serial_out_oe(lock_or_serial_out_oe), .synth_powered(synth_powered),
    .freq_change(freq_change), .autocal_start(autocal_start), .high_performance(high_performance),
    .low_current(low_current), .output_gain(output_gain), .mute_active(mute_active),
    .output_enable(output_enable));
